// ### hw/tses_defines.svh
// Constants of the thermal sensor event serial slave.
// Function
// - Temperature is 12-bit twos complement, 0.0625 C.
// - Limits are 10-bit twos complement, 0.25 C.
// - Bit 12 is the sign in temperature and limit words.
// - Limit magnitude bits 11:2; bits 1:0 ignored.
// - Negative reading is code minus 4096, over 16.
// - Event modes: interrupt, comparator, critical only.
// - Critical in interrupt mode forces comparator behaviour.
// - Critical event ignores the clear event bit.
// - Thresholds deassert with hysteresis from bits 10:9.
// - Window crossing in or out triggers event.
// - Clear event deasserts interrupt until next trigger.
// - Comparator event ignores register reads and writes.
// - Slave address is 0011 plus three pins.
// - Release data line after 75 ms idle.
// - Start, then address MSB first and direction.
// - Addressed slave drives acknowledge low.
// - Direction 0 writes, 1 reads.
// - Nine pulses per byte, data changes clock low.
// - Direction fixed until a new start.
// - Address pins latched on second own addressing.
// - Pointer resets to zero and holds value.
// - Two data bytes per write, extras ignored.
// - Top temperature bits show live trip status.
`ifndef TSES_DEFINES_SVH
`define TSES_DEFINES_SVH
`define TSES_CLK_MHZ 100
`define TSES_TIMEOUT_MS 75
`define TSES_AHB_TEMP 8'h00
`define TSES_AHB_STAT 8'h04
`define TSES_AHB_CFG 8'h08
`define TSES_PTR_CAP 8'h00
`define TSES_PTR_CFG 8'h01
`define TSES_PTR_UPPER 8'h02
`define TSES_PTR_LOWER 8'h03
`define TSES_PTR_CRIT 8'h04
`define TSES_PTR_TEMP 8'h05
`define TSES_PTR_MFG 8'h06
`define TSES_PTR_DEV 8'h07
`define TSES_ADDR_HI 4'h3
`define TSES_CFG_INT 0
`define TSES_CFG_CRIT_ONLY 2
`define TSES_CFG_EN 3
`define TSES_CFG_CLR 5
`define TSES_HYST_HI 10
`define TSES_HYST_LO 9
`define TSES_HYST_1P5 14'h0018
`define TSES_HYST_3 14'h0030
`define TSES_HYST_6 14'h0060
`define TSES_SIGN 12
`define TSES_LIM_HI 11
`define TSES_LIM_LO 2
`define TSES_CFG_RST 16'h0000
`define TSES_PTR_RST 8'h00
`define TSES_BYTE_PTR 2'h0
`define TSES_BYTE_MSB 2'h1
`define TSES_BYTE_LSB 2'h2
`define TSES_BYTE_DONE 2'h3
`define TSES_LAST_BIT 4'h7
`define TSES_BITS 4'h8
`endif

// ### hw/tses_pkg.sv
// Types shared by the thermal sensor event serial slave.
package tses_pkg;
	typedef enum logic [2:0] {
		TSES_IDLE, TSES_ADDR, TSES_AACK, TSES_WBYTE, TSES_WACK,
		TSES_RBYTE, TSES_RACK
	} tses_state_t;
	typedef struct packed {
		logic crit;
		logic above;
		logic below;
	} tses_trip_t;
endpackage : tses_pkg

// ### hw/tses_slave.sv
// Thermal sensor event logic with serial slave and AHB-Lite side port.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "tses_defines.svh"
module tses_slave #(
	parameter int TIMEOUT_CYC = `TSES_TIMEOUT_MS * `TSES_CLK_MHZ * 1000,
	parameter logic [15:0] CAP_WORD = 16'h0001,
	parameter logic [15:0] MFG_WORD = 16'h5a5a,
	parameter logic [15:0] DEV_WORD = 16'h0100
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_sel_bit0,
	input wire logic addr_sel_bit1,
	input wire logic addr_sel_bit2,
	input wire logic event_in,
	output logic event_out,
	output logic event_oe
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic [1:0] evp_s;
	logic [2:0] adr_s0;
	logic [2:0] adr_s1;
	logic scl_q;
	logic sda_q;
	tses_pkg::tses_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] rx;
	logic [7:0] tx;
	logic rw;
	logic mack;
	logic rd_hi;
	logic [1:0] byte_idx;
	logic [7:0] wr_msb;
	logic [7:0] pointer;
	logic [15:0] cfg;
	logic [10:0] lim_up;
	logic [10:0] lim_lo;
	logic [10:0] lim_cr;
	logic [12:0] temp;
	logic clr_evt;
	logic [1:0] match_cnt;
	logic locked;
	logic [2:0] addr_lat;
	logic [TW-1:0] to_cnt;
	tses_pkg::tses_trip_t flag;
	logic win_q;
	logic int_latch;
	logic dp_wr;
	logic [7:0] dp_addr;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Three stages on the clock and data lines, two on event and pins: the third copy is only for edge finding.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			evp_s <= 2'h3;
			adr_s0 <= 3'h0;
			adr_s1 <= 3'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl};
			sda_s <= {sda_s[0], sda_in};
			evp_s <= {evp_s[0], event_in};
			adr_s0 <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
			adr_s1 <= adr_s0;
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end

	wire scl_rise = scl_s[1] & ~scl_q;
	wire scl_fall = ~scl_s[1] & scl_q;
	wire start_c = scl_s[1] & scl_q & sda_q & ~sda_s[1];
	wire stop_c = scl_s[1] & scl_q & ~sda_q & sda_s[1];
	wire sda_chg = sda_s[1] ^ sda_q;
	wire timeout = to_cnt == TW'(TIMEOUT_CYC - 1);
	wire [2:0] addr_used = locked ? addr_lat : adr_s1;
	wire addr_hit = rx[6:0] == {`TSES_ADDR_HI, addr_used};
	// By the falling edge the direction bit is in, so the address sits higher.
	wire addr_full = rx[7:1] == {`TSES_ADDR_HI, addr_used};
	wire [7:0] rx_byte = {rx[6:0], sda_s[1]};

	// Sign-extended compares in temperature steps; limits gain two zeros.
	wire signed [13:0] t_s = {temp[`TSES_SIGN], temp};
	wire signed [13:0] up_s = {lim_up[10], lim_up, 2'b00};
	wire signed [13:0] lo_s = {lim_lo[10], lim_lo, 2'b00};
	wire signed [13:0] cr_s = {lim_cr[10], lim_cr, 2'b00};
	wire [1:0] hsel_cfg = cfg[`TSES_HYST_HI:`TSES_HYST_LO];
	wire signed [13:0] hyst = (hsel_cfg == 2'h1) ? `TSES_HYST_1P5 :
		(hsel_cfg == 2'h2) ? `TSES_HYST_3 :
		(hsel_cfg == 2'h3) ? `TSES_HYST_6 : 14'h0000;
	wire live_crit = t_s >= cr_s;
	wire live_above = t_s > up_s;
	wire live_below = t_s < lo_s;
	wire [2:0] trip_live = {live_crit, live_above, live_below};
	wire win_f = flag.above | flag.below;
	wire win_edge = win_f ^ win_q;
	wire mode_int = cfg[`TSES_CFG_INT];
	wire mode_crit = cfg[`TSES_CFG_CRIT_ONLY];
	wire evt_cond = mode_crit ? flag.crit :
		mode_int ? (int_latch | flag.crit) :
		(win_f | flag.crit);
	wire evt_on = cfg[`TSES_CFG_EN] & evt_cond;

	wire [15:0] rd_word =
		(pointer == `TSES_PTR_CFG) ? cfg :
		(pointer == `TSES_PTR_UPPER) ? {3'b000, lim_up, 2'b00} :
		(pointer == `TSES_PTR_LOWER) ? {3'b000, lim_lo, 2'b00} :
		(pointer == `TSES_PTR_CRIT) ? {3'b000, lim_cr, 2'b00} :
		(pointer == `TSES_PTR_TEMP) ? {trip_live, temp} :
		(pointer == `TSES_PTR_CAP) ? CAP_WORD :
		(pointer == `TSES_PTR_MFG) ? MFG_WORD :
		(pointer == `TSES_PTR_DEV) ? DEV_WORD : 16'h0000;
	wire [7:0] rd_byte = rd_hi ? rd_word[15:8] : rd_word[7:0];

	// Counts only while a transfer is open; any data line change restarts.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt <= '0;
		end else if (state == tses_pkg::TSES_IDLE || sda_chg || timeout) begin
			to_cnt <= '0;
		end else begin
			to_cnt <= to_cnt + TW'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= tses_pkg::TSES_IDLE;
			bitcnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			rw <= 1'b0;
			mack <= 1'b0;
			rd_hi <= 1'b1;
			byte_idx <= `TSES_BYTE_PTR;
			wr_msb <= 8'h00;
			pointer <= `TSES_PTR_RST;
			cfg <= `TSES_CFG_RST;
			lim_up <= 11'h000;
			lim_lo <= 11'h000;
			lim_cr <= 11'h000;
			clr_evt <= 1'b0;
			match_cnt <= 2'h0;
			locked <= 1'b0;
			addr_lat <= 3'h0;
			sda_oe <= 1'b0;
		end else begin
			clr_evt <= 1'b0;
			if (timeout || stop_c) begin
				state <= tses_pkg::TSES_IDLE;
				sda_oe <= 1'b0;
			end else if (start_c) begin
				state <= tses_pkg::TSES_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
				tses_pkg::TSES_ADDR, tses_pkg::TSES_WBYTE,
				tses_pkg::TSES_RBYTE: begin
					rx <= rx_byte;
					bitcnt <= bitcnt + 4'h1;
				end
				tses_pkg::TSES_RACK: begin
					mack <= ~sda_s[1];
				end
				default: begin
				end
				endcase
				if (state == tses_pkg::TSES_ADDR && bitcnt == `TSES_LAST_BIT &&
					addr_hit) begin
					rw <= sda_s[1];
					rd_hi <= 1'b1;
					byte_idx <= `TSES_BYTE_PTR;
					if (match_cnt != 2'h2) begin
						match_cnt <= match_cnt + 2'h1;
					end
					if (match_cnt == 2'h1 && !locked) begin
						locked <= 1'b1;
						addr_lat <= adr_s1;
					end
				end
				if (state == tses_pkg::TSES_WBYTE && bitcnt == `TSES_LAST_BIT) begin
					if (byte_idx != `TSES_BYTE_DONE) begin
						byte_idx <= byte_idx + 2'h1;
					end
					case (byte_idx)
					`TSES_BYTE_PTR: pointer <= rx_byte;
					`TSES_BYTE_MSB: wr_msb <= rx_byte;
					`TSES_BYTE_LSB: begin
						if (pointer == `TSES_PTR_CFG) begin
							cfg <= {wr_msb, rx_byte};
							cfg[`TSES_CFG_CLR] <= 1'b0;
							clr_evt <= rx_byte[`TSES_CFG_CLR];
						end else if (pointer == `TSES_PTR_UPPER) begin
							lim_up <= {wr_msb[4:0], rx_byte[7:2]};
						end else if (pointer == `TSES_PTR_LOWER) begin
							lim_lo <= {wr_msb[4:0], rx_byte[7:2]};
						end else if (pointer == `TSES_PTR_CRIT) begin
							lim_cr <= {wr_msb[4:0], rx_byte[7:2]};
						end
					end
					default: begin
					end
					endcase
				end
			end else if (scl_fall) begin
				case (state)
				tses_pkg::TSES_ADDR: begin
					if (bitcnt == `TSES_BITS) begin
						state <= addr_full ? tses_pkg::TSES_AACK :
							tses_pkg::TSES_IDLE;
						sda_oe <= addr_full;
					end
				end
				tses_pkg::TSES_AACK: begin
					bitcnt <= 4'h0;
					if (rw) begin
						state <= tses_pkg::TSES_RBYTE;
						tx <= rd_byte;
						sda_oe <= ~rd_byte[7];
						rd_hi <= ~rd_hi;
					end else begin
						state <= tses_pkg::TSES_WBYTE;
						sda_oe <= 1'b0;
					end
				end
				tses_pkg::TSES_WBYTE: begin
					if (bitcnt == `TSES_BITS) begin
						state <= tses_pkg::TSES_WACK;
						sda_oe <= 1'b1;
					end
				end
				tses_pkg::TSES_WACK: begin
					state <= tses_pkg::TSES_WBYTE;
					bitcnt <= 4'h0;
					sda_oe <= 1'b0;
				end
				tses_pkg::TSES_RBYTE: begin
					if (bitcnt == `TSES_BITS) begin
						state <= tses_pkg::TSES_RACK;
						sda_oe <= 1'b0;
					end else begin
						sda_oe <= ~tx[3'h7 - bitcnt[2:0]];
					end
				end
				tses_pkg::TSES_RACK: begin
					if (mack) begin
						state <= tses_pkg::TSES_RBYTE;
						bitcnt <= 4'h0;
						tx <= rd_byte;
						sda_oe <= ~rd_byte[7];
						rd_hi <= ~rd_hi;
					end else begin
						state <= tses_pkg::TSES_IDLE;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// Hysteretic trip flags: critical sets at its threshold, window flags beyond theirs; critical released past the hysteresis, window flags at it.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= '0;
			win_q <= 1'b0;
		end else begin
			win_q <= win_f;
			if (t_s >= cr_s) begin
				flag.crit <= 1'b1;
			end else if (t_s < cr_s - hyst) begin
				flag.crit <= 1'b0;
			end
			if (t_s > up_s) begin
				flag.above <= 1'b1;
			end else if (t_s <= up_s - hyst) begin
				flag.above <= 1'b0;
			end
			if (t_s < lo_s) begin
				flag.below <= 1'b1;
			end else if (t_s >= lo_s + hyst) begin
				flag.below <= 1'b0;
			end
		end
	end

	// A crossing in the same cycle as a clear keeps the event raised.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			int_latch <= 1'b0;
		end else if (!mode_int || mode_crit) begin
			int_latch <= 1'b0;
		end else if (win_edge) begin
			int_latch <= 1'b1;
		end else if (clr_evt) begin
			int_latch <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			event_oe <= 1'b0;
		end else begin
			event_oe <= evt_on;
		end
	end

	assign event_out = 1'b0;
	assign sda_out = 1'b0;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire ahb_go = hsel & hready & htrans[1];
	wire [31:0] stat_word = {8'h00, pointer, 6'h00, evp_s[1], addr_used,
		locked, int_latch, flag.crit, flag.above, flag.below, event_oe};
	wire [31:0] rd_mux = (haddr == `TSES_AHB_TEMP) ? {19'h0, temp} :
		(haddr == `TSES_AHB_STAT) ? stat_word :
		(haddr == `TSES_AHB_CFG) ? {16'h0000, cfg} : 32'h0000_0000;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			dp_wr <= ahb_go & hwrite;
			dp_addr <= haddr;
			if (ahb_go && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			temp <= 13'h0000;
		end else if (dp_wr && dp_addr == `TSES_AHB_TEMP) begin
			temp <= hwdata[12:0];
		end
	end

	crit_forces_a: assert property (
		cfg[`TSES_CFG_EN] && flag.crit |=> event_oe)
		else $error("critical trip did not assert event");
	crit_no_clear_a: assert property (
		clr_evt && flag.crit && cfg[`TSES_CFG_EN] |=> ##1 event_oe)
		else $error("clear event dropped a critical event");
	int_clear_a: assert property (
		mode_int && !mode_crit && clr_evt && !win_edge && !flag.crit
		|=> !int_latch ##1 !event_oe)
		else $error("clear event did not deassert interrupt");
	window_edge_a: assert property (
		mode_int && !mode_crit && win_edge |=> int_latch)
		else $error("window crossing missed");
	cmp_quiet_a: assert property (
		!mode_int && $stable(flag) && $stable(cfg) |=> $stable(event_oe))
		else $error("comparator event moved without cause");
	hyst_release_a: assert property (
		$fell(flag.crit) |-> $past(t_s) < $past(cr_s) - $past(hyst))
		else $error("critical flag released inside hysteresis");
	ack_drive_a: assert property (
		state == tses_pkg::TSES_AACK |-> sda_oe && $past(addr_full))
		else $error("acknowledge not driven low");
	idle_release_a: assert property (
		timeout |=> state == tses_pkg::TSES_IDLE && !sda_oe)
		else $error("data line not released on timeout");
	addr_lock_a: assert property (
		locked |=> locked && $stable(addr_lat))
		else $error("latched address moved");
	oe_on_low_a: assert property (
		$changed(sda_oe) && state != tses_pkg::TSES_IDLE |-> !scl_s[1] || stop_c
		|| start_c || timeout || $past(timeout))
		else $error("data line changed with clock high");
endmodule : tses_slave

// ### tb/tses_master.sv
// Serial bus master model that faces the sensor slave.
`timescale 1ns/1ps
module tses_master (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// The clock stands high between frames and the data line idles released.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic q();
		repeat (4) @(posedge mclk);
	endtask : q
	task automatic start();
		sda_low <= 1'b0;
		scl <= 1'b1;
		q();
		sda_low <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask : start
	// The data line moves only in the low half of the clock.
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		q();
		scl <= 1'b1;
		q();
		r = sda;
		q();
		scl <= 1'b0;
		q();
	endtask : bit_io
	task automatic stop();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b0;
		q();
	endtask : stop
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : put
	// The last byte of a read is left without acknowledge.
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : get
endmodule : tses_master

// ### tb/tses_slave_tb_top.sv
// Self-checking bench for the thermal sensor event serial slave.
`timescale 1ns/1ps
module tses_slave_tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rd_ph = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] pins = 3'h5;
	logic [6:0] adr = 7'h1d;
	logic hreadyout, hresp, sda_out, sda_oe, event_out, event_oe, scl;
	logic sda_low, a;
	logic [31:0] hrdata;
	logic [12:0] t;
	logic [12:0] tab [6] = '{13'h1c90, 13'h0190, 13'h07d0, 13'h1fff,
		13'h0640, 13'h1e70};
	logic [63:0] exp_q [$];
	logic [31:0] seen_q [$];
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	// The open-drain data line has a pull-up.
	wire sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
	tses_slave #(.TIMEOUT_CYC(2000), .CAP_WORD(16'h0c3a)) tses_slave_inst (
		.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_sel_bit0(pins[0]), .addr_sel_bit1(pins[1]),
		.addr_sel_bit2(pins[2]), .event_in(event_oe ? event_out : 1'b1),
		.event_out(event_out), .event_oe(event_oe));
	tses_master mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
	always #5 mclk = ~mclk;
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [63:0] e);
		checks++;
		if ((got & e[63:32]) !== e[31:0]) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, got & e[63:32],
				e[31:0]);
		end
	endtask : chk
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		// An error response inverts the word so that any masked compare trips.
		if (rd_ph && hreadyout)
			seen_q.push_back(hrdata ^ {32{hresp}});
		while (seen_q.size() > 0 && exp_q.size() > 0)
			chk(seen_q.pop_front(), exp_q.pop_front());
		if (cyc == 60000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic note(input logic [31:0] m, input logic [31:0] v);
		exp_q.push_back({m, v});
	endtask : note
	task automatic ahb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask : ahb
	task automatic swr(input logic [7:0] p, input logic [15:0] v, input int n);
		mst.start();
		mst.put({adr, 1'b0}, a);
		mst.put(p, a);
		for (int i = 0; i < n; i++)
			mst.put(i == 1 ? v[7:0] : v[15:8], a);
		mst.stop();
	endtask : swr
	task automatic srd(input logic [7:0] p, input logic set);
		logic [7:0] hi, lo;
		if (set) begin
			mst.start();
			mst.put({adr, 1'b0}, a);
			mst.put(p, a);
		end
		mst.start();
		mst.put({adr, 1'b1}, a);
		mst.get(1'b0, hi);
		mst.get(1'b1, lo);
		mst.stop();
		seen_q.push_back({16'h0, hi, lo});
	endtask : srd
	task automatic ping(input logic [6:0] a7, input logic ack);
		note(32'h1, {31'h0, ack});
		mst.start();
		mst.put({a7, 1'b0}, a);
		mst.stop();
		seen_q.push_back({31'h0, a});
	endtask : ping
	task automatic tev(input logic [12:0] v, input logic ev);
		ahb(1'b1, 8'h00, {19'h0, v});
		repeat (8) @(posedge mclk);
		note(32'h201, {22'h0, !ev, 8'h0, ev});
		ahb(1'b0, 8'h04, 32'h0);
	endtask : tev
	// Limits are upper 50 C, lower -25 C and critical 100 C here.
	function automatic logic [15:0] tword(input logic [12:0] v);
		int ti;
		ti = $signed(v);
		return {ti >= 1600, ti > 800, ti < -400, v};
	endfunction : tword
	initial begin
		void'($urandom(32'he17e6a96));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		note(32'h00ff0201, 32'h200);
		ahb(1'b0, 8'h04, 32'h0);
		note(32'hffffffff, 32'h0);
		ahb(1'b0, 8'h08, 32'h0);
		note(32'hffff, 32'h0c3a);
		srd(8'h00, 1'b0);
		ping(7'h1c, 1'b0);
		ping(adr, 1'b1);
		pins <= 3'h2;
		repeat (8) @(posedge mclk);
		ping(adr, 1'b1);
		ping(7'h1a, 1'b0);
		swr(8'h02, 16'he323, 3);
		note(32'hffff, 32'h0320);
		srd(8'h02, 1'b1);
		swr(8'h03, 16'h1e73, 2);
		swr(8'h04, 16'h0642, 2);
		for (int i = 0; i < 12; i++) begin
			t = (i < 6) ? tab[i] : 13'($urandom);
			ahb(1'b1, 8'h00, {19'h0, t});
			note(32'hffff, {16'h0, tword(t)});
			srd(8'h05, i == 0);
		end
		swr(8'h03, 16'h00a0, 2);
		swr(8'h01, 16'h0208, 2);
		tev(13'h0190, 1'b0);
		tev(13'h03c0, 1'b1);
		swr(8'h01, 16'h0228, 2);
		tev(13'h03c0, 1'b1);
		tev(13'h0310, 1'b1);
		tev(13'h0300, 1'b0);
		tev(13'h0050, 1'b1);
		tev(13'h00b0, 1'b1);
		tev(13'h00c0, 1'b0);
		swr(8'h01, 16'h0229, 2);
		tev(13'h0190, 1'b0);
		tev(13'h03c0, 1'b1);
		swr(8'h01, 16'h0229, 2);
		tev(13'h03c0, 1'b0);
		tev(13'h0640, 1'b1);
		swr(8'h01, 16'h0229, 2);
		tev(13'h0640, 1'b1);
		tev(13'h03c0, 1'b0);
		swr(8'h01, 16'h020c, 2);
		tev(13'h03c0, 1'b0);
		tev(13'h0640, 1'b1);
		ahb(1'b1, 8'h00, 32'h0190);
		note(32'hffff, 32'h0190);
		srd(8'h05, 1'b1);
		mst.start();
		mst.put({adr, 1'b1}, a);
		repeat (8) @(posedge mclk);
		note(32'h1, 32'h0);
		seen_q.push_back({31'h0, sda});
		repeat (2100) @(posedge mclk);
		note(32'h1, 32'h1);
		seen_q.push_back({31'h0, sda});
		mst.stop();
		repeat (20) @(posedge mclk);
		if (exp_q.size() != 0)
			mismatches++;
		final_report();
	end
endmodule : tses_slave_tb_top
